// ==== hw/dcdp_core.sv ====
// dma channel data process core: registers, flow, fifos, two ports
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Function
// - separate arbiters for memory and peripheral ports
// - highest level wins, lower channel on ties
// - 8, 16, 32 bit widths per side
// - multi-data mode packs and unpacks mismatched widths
// - single-data enable forces memory width to peripheral
// - single or incrementing 4, 8, 16 beat bursts
// - single-data enable forces both bursts single
// - one burst per peripheral request, remainder singles
// - bursts crossing 1KB split into singles
// - peripheral flow control forces count all ones, except in memory-to-memory
// - count drops per peripheral beat, shows remaining
// - each channel owns four-word 32-bit fifo
// - memory-to-memory always uses multi-data mode
// - multi-mode bit (fifo control bit 2) set to one selects multi-data mode
// - source served only with room for transfer
// - peripheral destination served with one burst available
// - memory destination drains fifo after threshold reached
// - single-data reads when empty, writes when not
// - direction codes; code 11 disables the channel
module dcdp_core
  import dcdp_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [31:0]     wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [NCH-1:0]  periph_req_i,
  output logic      [NCH-1:0]  periph_ack_o,
  output logic                 mem_valid_o,
  output logic                 mem_we_o,
  output logic      [31:0]     mem_addr_o,
  output logic      [1:0]      mem_size_o,
  output logic      [1:0]      mem_burst_o,
  output logic      [31:0]     mem_wdata_o,
  input  wire logic            mem_ready_i,
  input  wire logic [31:0]     mem_rdata_i,
  output logic                 per_valid_o,
  output logic                 per_we_o,
  output logic      [31:0]     per_addr_o,
  output logic      [1:0]      per_size_o,
  output logic      [1:0]      per_burst_o,
  output logic      [31:0]     per_wdata_o,
  input  wire logic            per_ready_i,
  input  wire logic [31:0]     per_rdata_i
);
  logic [15:0]           ctrl_reg  [NCH];
  logic [15:0]           ctrl_next [NCH];
  logic [15:0]           cnt_reg   [NCH];
  logic [15:0]           cnt_next  [NCH];
  logic [31:0]           pa_reg    [NCH];
  logic [31:0]           pa_next   [NCH];
  logic [31:0]           ma_reg    [NCH];
  logic [31:0]           ma_next   [NCH];
  logic [2:0]            fc_reg    [NCH];
  logic [2:0]            fc_next   [NCH];
  logic [NCH-1:0]        drain_reg, drain_next, flush;
  logic [NCH-1:0]        rq_meta_reg, rq_meta_next;
  logic [NCH-1:0]        rq_reg, rq_next;
  logic                  ack_reg, ack_next;
  logic [31:0]           dat_reg, dat_next;
  logic [4:0]            lvl       [NCH];
  logic [31:0]           frd       [NCH];
  logic [NCH-1:0]        push, pop;
  logic [2:0]            push_n    [NCH];
  logic [2:0]            pop_n     [NCH];
  logic [31:0]           push_d    [NCH];
  logic [NCH-1:0]        p_elig, m_elig, p_we, m_we;
  logic [NCH-1:0][1:0]   priority_level_field, p_size, m_size, p_bu, m_bu;
  logic [NCH-1:0][4:0]   p_beats, m_beats;
  logic [NCH-1:0][31:0]  p_addr, m_addr;
  logic                  p_start, p_beat, m_beat;
  logic [CHW-1:0]        p_gnt, m_gnt;
  logic                  wb_hit;
  logic [CHW-1:0]        wch;
  logic [4:0]            wof;

  // byte-enable merge of a bus write
  function automatic logic [31:0] bmask(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      bmask[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
  endfunction

  // width and multi-data mode lookups for a channel
  function automatic logic [2:0] pw_b(input logic [15:0] c);
    pw_b = wbytes(c[CTL_PW +: 2]);
  endfunction
  function automatic logic [2:0] mw_b(input logic [15:0] c);
    mw_b = wbytes(c[CTL_MW +: 2]);
  endfunction
  function automatic logic is_multi(input logic [15:0] c,
                                    input logic [2:0] f);
    is_multi = f[FCTL_MULTI] | (c[CTL_DIR +: 2] == DIR_M2M);
  endfunction

  // peripheral request pins pass two flops
  assign rq_meta_next = periph_req_i;
  assign rq_next      = rq_meta_reg;

  // wishbone slave decode, one-cycle registered answer
  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wch    = wb_adr_i[WIN_LO +: CHW];
  assign wof    = wb_adr_i[4:0];
  always_comb begin
    ack_next = wb_hit;
    dat_next = 32'h0000_0000;
    if (wb_hit && !wb_we_i && wb_adr_i[31:8] == 24'h00_0000) begin
      case (wof)
        OFF_CTRL:  dat_next = {16'h0000, ctrl_reg[wch]};
        OFF_COUNT: dat_next = {16'h0000, cnt_reg[wch]};
        OFF_PADDR: dat_next = pa_reg[wch];
        OFF_MADDR: dat_next = ma_reg[wch];
        OFF_FCTL:  dat_next = {23'h0, lvl[wch], 1'b0, fc_reg[wch]};
        default:   dat_next = 32'h0000_0000;
      endcase
    end
  end

  // per channel: which port may be served and with how many beats
  always_comb begin
    logic [1:0] dir;
    logic       mu, ok, big;
    logic [2:0] pby, mby;
    logic [4:0] pf, mf, room;
    logic [6:0] need, full;
    logic [19:0] left;
    dir = 2'h0; mu = 1'b0; ok = 1'b0; big = 1'b0;
    pby = 3'h0; mby = 3'h0; pf = 5'h0; mf = 5'h0; room = 5'h0;
    need = 7'h0; full = 7'h0; left = 20'h0;
    for (int c = 0; c < NCH; c++) begin
      dir  = ctrl_reg[c][CTL_DIR +: 2];
      mu   = is_multi(ctrl_reg[c], fc_reg[c]);
      pby  = pw_b(ctrl_reg[c]);
      mby  = mw_b(ctrl_reg[c]);
      pf   = bbeats(ctrl_reg[c][CTL_PB +: 2]);
      mf   = bbeats(ctrl_reg[c][CTL_MB +: 2]);
      room = FIFO_BYTES - lvl[c];
      priority_level_field[c]   = ctrl_reg[c][CTL_PRIORITY_LEVEL_FIELD +: 2];
      p_addr[c] = pa_reg[c];
      m_addr[c] = ma_reg[c];
      // peripheral port: burst per request, short tail as singles
      p_beats[c] = (cnt_reg[c] >= {11'h0, pf}) ? pf : 5'h01;
      need       = xbytes(p_beats[c], pby);
      p_bu[c]    = (p_beats[c] == 5'h01) ? BURST_SINGLE
                                         : ctrl_reg[c][CTL_PB +: 2];
      p_size[c]  = ctrl_reg[c][CTL_PW +: 2];
      p_we[c]    = (dir == DIR_M2P);
      if (dir == DIR_M2P)
        ok = mu ? ({2'h0, lvl[c]} >= need) : (lvl[c] != 5'h0);
      else
        ok = mu ? ({2'h0, room} >= need) : (lvl[c] == 5'h0);
      p_elig[c] = ctrl_reg[c][CTL_EN] & (cnt_reg[c] != 16'h0) & ok
                & ((dir == DIR_M2M) | rq_reg[c]);
      // memory port: fill as source, drain as destination
      left = ({4'h0, cnt_reg[c]} * {17'h0, pby}) - {15'h0, lvl[c]};
      full = xbytes(mf, mby);
      if (dir == DIR_M2P) begin
        big = mu & (mf != 5'h01) & (left >= {13'h0, full})
            & ({2'h0, room} >= full);
        ok  = mu ? ((room >= {2'h0, mby}) & (left >= {17'h0, mby}))
                 : ((lvl[c] == 5'h0) & (left != 20'h0));
      end else begin
        big = mu & (mf != 5'h01) & ({2'h0, lvl[c]} >= full);
        ok  = (lvl[c] >= {2'h0, mby}) & (~mu | drain_reg[c]);
      end
      m_beats[c] = big ? mf : 5'h01;
      m_bu[c]    = big ? ctrl_reg[c][CTL_MB +: 2] : BURST_SINGLE;
      m_size[c]  = ctrl_reg[c][CTL_MW +: 2];
      m_we[c]    = (dir != DIR_M2P);
      m_elig[c]  = ctrl_reg[c][CTL_EN] & ok;
    end
  end

  // fifo traffic: source beats push, destination beats pop
  always_comb begin
    logic ps;
    ps = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      ps = (ctrl_reg[c][CTL_DIR +: 2] != DIR_M2P);
      push[c]   = (p_beat & (p_gnt == CHW'(c)) & ps)
                | (m_beat & (m_gnt == CHW'(c)) & ~ps);
      pop[c]    = (p_beat & (p_gnt == CHW'(c)) & ~ps)
                | (m_beat & (m_gnt == CHW'(c)) & ps);
      push_n[c] = ps ? pw_b(ctrl_reg[c]) : mw_b(ctrl_reg[c]);
      pop_n[c]  = ps ? mw_b(ctrl_reg[c]) : pw_b(ctrl_reg[c]);
      push_d[c] = ps ? per_rdata_i : mem_rdata_i;
      periph_ack_o[c] = p_start & (p_gnt == CHW'(c))
                      & (ctrl_reg[c][CTL_DIR +: 2] != DIR_M2M);
    end
  end

  // channel registers: software writes, enable forcing, progress
  always_comb begin
    logic [15:0] v;
    logic [4:0]  thr;
    logic        hit, bsy;
    v = 16'h0; thr = 5'h0; hit = 1'b0; bsy = 1'b0;
    ctrl_next  = ctrl_reg;
    cnt_next   = cnt_reg;
    pa_next    = pa_reg;
    ma_next    = ma_reg;
    fc_next    = fc_reg;
    drain_next = drain_reg;
    flush      = '0;
    for (int c = 0; c < NCH; c++) begin
      // beats advance counter and addresses
      if (p_beat && p_gnt == CHW'(c)) begin
        cnt_next[c] = cnt_reg[c] - 16'h0001;
        pa_next[c]  = pa_reg[c] + {29'h0, pw_b(ctrl_reg[c])};
      end
      if (m_beat && m_gnt == CHW'(c))
        ma_next[c] = ma_reg[c] + {29'h0, mw_b(ctrl_reg[c])};
      // drain starts at threshold or at the tail, ends when empty
      thr = 5'(({3'h0, fc_reg[c][FCTL_THR +: 2]} + 5'h01) << 2);
      if (lvl[c] == 5'h0)
        drain_next[c] = 1'b0;
      else if (lvl[c] >= thr || cnt_reg[c] == 16'h0)
        drain_next[c] = 1'b1;
      // channel finishes when count and fifo are both spent
      bsy = (p_valid_busy(c)) | (mem_valid_o && m_gnt == CHW'(c));
      if (ctrl_reg[c][CTL_EN] && cnt_reg[c] == 16'h0
          && lvl[c] == 5'h0 && !bsy)
        ctrl_next[c][CTL_EN] = 1'b0;
      hit = wb_hit & wb_we_i & (wb_adr_i[31:8] == 24'h00_0000)
          & (wch == CHW'(c));
      if (hit && wof == OFF_CTRL) begin
        v = 16'(bmask({16'h0, ctrl_reg[c]}, wb_dat_i, wb_sel_i));
        if (ctrl_reg[c][CTL_EN]) begin
          // while running only the enable bit may change
          ctrl_next[c][CTL_EN] = v[CTL_EN];
        end else begin
          if (v[CTL_EN]) begin
            flush[c] = 1'b1;
            if (!is_multi(v, fc_reg[c])) begin
              v[CTL_MW +: 2] = v[CTL_PW +: 2];
              v[CTL_PB +: 2] = BURST_SINGLE;
              v[CTL_MB +: 2] = BURST_SINGLE;
            end
            if (v[CTL_PFC] && v[CTL_DIR +: 2] != DIR_M2M)
              cnt_next[c] = COUNT_FLOW;
            if (v[CTL_DIR +: 2] == DIR_BAD)
              v[CTL_EN] = 1'b0;
          end
          ctrl_next[c] = v;
        end
      end
      // setup registers are locked while the channel runs
      if (hit && !ctrl_reg[c][CTL_EN]) begin
        if (wof == OFF_COUNT)
          cnt_next[c] = 16'(bmask({16'h0, cnt_reg[c]}, wb_dat_i,
                                  wb_sel_i));
        if (wof == OFF_PADDR)
          pa_next[c] = bmask(pa_reg[c], wb_dat_i, wb_sel_i);
        if (wof == OFF_MADDR)
          ma_next[c] = bmask(ma_reg[c], wb_dat_i, wb_sel_i);
        if (wof == OFF_FCTL)
          fc_next[c] = 3'(bmask({29'h0, fc_reg[c]}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // peripheral port holds this channel
  function automatic logic p_valid_busy(input int c);
    p_valid_busy = per_valid_o && (p_gnt == CHW'(c));
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= '{default: CTRL_RST};
      cnt_reg     <= '{default: COUNT_RST};
      pa_reg      <= '{default: ADDR_RST};
      ma_reg      <= '{default: ADDR_RST};
      fc_reg      <= '{default: FCTL_RST};
      drain_reg   <= '0;
      rq_meta_reg <= '0;
      rq_reg      <= '0;
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h0000_0000;
    end else begin
      ctrl_reg    <= ctrl_next;
      cnt_reg     <= cnt_next;
      pa_reg      <= pa_next;
      ma_reg      <= ma_next;
      fc_reg      <= fc_next;
      drain_reg   <= drain_next;
      rq_meta_reg <= rq_meta_next;
      rq_reg      <= rq_next;
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // one fifo per channel
  for (genvar g = 0; g < NCH; g++) begin : g_fifo
    dcdp_fifo u_fifo (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .flush_i  (flush[g]),
      .push_i   (push[g]),
      .push_n_i (push_n[g]),
      .push_d_i (push_d[g]),
      .pop_i    (pop[g]),
      .pop_n_i  (pop_n[g]),
      .rdata_o  (frd[g]),
      .level_o  (lvl[g])
    );
  end

  // peripheral side master with its own arbiter
  dcdp_port u_per (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .elig_i  (p_elig),
    .priority_level_field_i  (priority_level_field),
    .beats_i (p_beats),
    .size_i  (p_size),
    .burst_i (p_bu),
    .we_i    (p_we),
    .addr_i  (p_addr),
    .ready_i (per_ready_i),
    .valid_o (per_valid_o),
    .we_o    (per_we_o),
    .addr_o  (per_addr_o),
    .size_o  (per_size_o),
    .burst_o (per_burst_o),
    .start_o (p_start),
    .beat_o  (p_beat),
    .grant_o (p_gnt)
  );

  // memory side master with its own arbiter
  dcdp_port u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .elig_i  (m_elig),
    .priority_level_field_i  (priority_level_field),
    .beats_i (m_beats),
    .size_i  (m_size),
    .burst_i (m_bu),
    .we_i    (m_we),
    .addr_i  (m_addr),
    .ready_i (mem_ready_i),
    .valid_o (mem_valid_o),
    .we_o    (mem_we_o),
    .addr_o  (mem_addr_o),
    .size_o  (mem_size_o),
    .burst_o (mem_burst_o),
    .start_o (),
    .beat_o  (m_beat),
    .grant_o (m_gnt)
  );

  // write data straight from the granted fifo head register
  assign per_wdata_o = frd[p_gnt];
  assign mem_wdata_o = frd[m_gnt];
endmodule
`default_nettype wire

// ==== pkg/dcdp_pkg.sv ====
// shared constants and helpers for the dma channel data process core
package dcdp_pkg;
  localparam int         NCH          = 8;
  localparam int         CHW          = 3;
  localparam int         WIN_LO       = 5;
  localparam int         FIFO_B       = 16;
  // register offsets inside one channel window
  localparam logic [4:0] OFF_CTRL     = 5'h00;
  localparam logic [4:0] OFF_COUNT    = 5'h04;
  localparam logic [4:0] OFF_PADDR    = 5'h08;
  localparam logic [4:0] OFF_MADDR    = 5'h0C;
  localparam logic [4:0] OFF_FCTL     = 5'h10;
  // channel_control_reg fields
  localparam int         CTL_EN       = 0;
  localparam int         CTL_DIR      = 1;
  localparam int         CTL_PW       = 3;
  localparam int         CTL_MW       = 5;
  localparam int         CTL_PB       = 7;
  localparam int         CTL_MB       = 9;
  localparam int         CTL_PRIORITY_LEVEL_FIELD     = 11;
  localparam int         CTL_PFC      = 13;
  // channel_fifo_control_reg fields
  localparam int         FCTL_THR     = 0;
  localparam int         FCTL_MULTI   = 2;
  localparam int         FCTL_LVL     = 4;
  // reset and forced values
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] COUNT_FLOW  = 16'hFFFF;
  localparam logic [31:0] ADDR_RST    = 32'h0000_0000;
  localparam logic [2:0]  FCTL_RST    = 3'h0;
  // encodings
  localparam logic [1:0] DIR_P2M      = 2'h0;
  localparam logic [1:0] DIR_M2P      = 2'h1;
  localparam logic [1:0] DIR_M2M      = 2'h2;
  localparam logic [1:0] DIR_BAD      = 2'h3;
  localparam logic [1:0] BURST_SINGLE = 2'h0;
  localparam logic [10:0] KB_BOUNDARY = 11'h400;
  localparam logic [4:0] FIFO_BYTES   = 5'h10;

  typedef enum logic [0:0] {DCDP_IDLE, DCDP_BUSY} dcdp_port_st_t;

  // bytes per beat from a width code
  function automatic logic [2:0] wbytes(input logic [1:0] w);
    wbytes = (w == 2'h0) ? 3'h1 : (w == 2'h1) ? 3'h2 : 3'h4;
  endfunction

  // beats per burst from a burst code
  function automatic logic [4:0] bbeats(input logic [1:0] b);
    bbeats = (b == 2'h0) ? 5'h01 : (b == 2'h1) ? 5'h04 :
             (b == 2'h2) ? 5'h08 : 5'h10;
  endfunction

  // bytes moved by a number of beats
  function automatic logic [6:0] xbytes(input logic [4:0] n,
                                        input logic [2:0] w);
    xbytes = {2'h0, n} * {4'h0, w};
  endfunction
endpackage

// ==== hw/dcdp_fifo.sv ====
// byte-lane channel fifo, four words deep, registered read data
`timescale 1ns/100ps
`default_nettype none
module dcdp_fifo
  import dcdp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        flush_i,
  input  wire logic        push_i,
  input  wire logic [2:0]  push_n_i,
  input  wire logic [31:0] push_d_i,
  input  wire logic        pop_i,
  input  wire logic [2:0]  pop_n_i,
  output logic      [31:0] rdata_o,
  output logic      [4:0]  level_o
);
  logic [7:0]  mem_reg  [FIFO_B];
  logic [7:0]  mem_next [FIFO_B];
  logic [3:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic [4:0]  lvl_reg, lvl_next;
  logic [31:0] rd_reg, rd_next;

  // byte pointers move by beat width, so widths pack and unpack
  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    lvl_next = lvl_reg;
    rd_next  = 32'h0000_0000;
    if (flush_i) begin
      wp_next  = 4'h0;
      rp_next  = 4'h0;
      lvl_next = 5'h00;
    end else begin
      if (push_i) begin
        for (int i = 0; i < 4; i++) begin
          if (3'(i) < push_n_i)
            mem_next[wp_reg + 4'(i)] = push_d_i[8*i +: 8];
        end
        wp_next = wp_reg + {1'b0, push_n_i};
      end
      if (pop_i)
        rp_next = rp_reg + {1'b0, pop_n_i};
      lvl_next = lvl_reg + (push_i ? {2'h0, push_n_i} : 5'h00)
                         - (pop_i ? {2'h0, pop_n_i} : 5'h00);
    end
    // head bytes already reflect this cycle's push and pop
    for (int i = 0; i < 4; i++)
      rd_next[8*i +: 8] = mem_next[rp_next + 4'(i)];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_reg <= '{default: 8'h00};
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      lvl_reg <= 5'h00;
      rd_reg  <= 32'h0000_0000;
    end else begin
      mem_reg <= mem_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      lvl_reg <= lvl_next;
      rd_reg  <= rd_next;
    end
  end

  assign rdata_o = rd_reg;
  assign level_o = lvl_reg;
endmodule
`default_nettype wire

// ==== hw/dcdp_port.sv ====
// one master port: channel arbiter plus beat sequencer
`timescale 1ns/100ps
`default_nettype none
module dcdp_port
  import dcdp_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [NCH-1:0]       elig_i,
  input  wire logic [NCH-1:0][1:0]  priority_level_field_i,
  input  wire logic [NCH-1:0][4:0]  beats_i,
  input  wire logic [NCH-1:0][1:0]  size_i,
  input  wire logic [NCH-1:0][1:0]  burst_i,
  input  wire logic [NCH-1:0]       we_i,
  input  wire logic [NCH-1:0][31:0] addr_i,
  input  wire logic                 ready_i,
  output logic                      valid_o,
  output logic                      we_o,
  output logic      [31:0]          addr_o,
  output logic      [1:0]           size_o,
  output logic      [1:0]           burst_o,
  output logic                      start_o,
  output logic                      beat_o,
  output logic      [CHW-1:0]       grant_o
);
  dcdp_port_st_t  st_reg, st_next;
  logic [CHW-1:0] ch_reg, ch_next, pick;
  logic [4:0]     left_reg, left_next;
  logic           we_reg, we_next;
  logic [1:0]     sz_reg, sz_next, bu_reg, bu_next;

  // highest level wins, lowest channel on a tie
  function automatic logic [CHW-1:0] arb_pick(
      input logic [NCH-1:0] el, input logic [NCH-1:0][1:0] pr);
    logic [1:0] best;
    best     = 2'h0;
    arb_pick = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (el[c] && pr[c] >= best) begin
        arb_pick = CHW'(c);
        best     = pr[c];
      end
    end
  endfunction

  // take a winner when idle, then run its beats
  always_comb begin
    pick      = arb_pick(elig_i, priority_level_field_i);
    st_next   = st_reg;
    ch_next   = ch_reg;
    left_next = left_reg;
    we_next   = we_reg;
    sz_next   = sz_reg;
    bu_next   = bu_reg;
    start_o   = 1'b0;
    case (st_reg)
      DCDP_IDLE: begin
        if (|elig_i) begin
          start_o   = 1'b1;
          st_next   = DCDP_BUSY;
          ch_next   = pick;
          left_next = beats_i[pick];
          we_next   = we_i[pick];
          sz_next   = size_i[pick];
          // a burst over a 1KB line goes out as singles
          bu_next   = (({1'b0, addr_i[pick][9:0]} + {4'h0,
                      xbytes(beats_i[pick], wbytes(size_i[pick]))})
                      > KB_BOUNDARY) ? BURST_SINGLE : burst_i[pick];
        end
      end
      DCDP_BUSY: begin
        if (ready_i) begin
          left_next = left_reg - 5'h01;
          if (left_reg == 5'h01)
            st_next = DCDP_IDLE;
        end
      end
      default: st_next = DCDP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg   <= DCDP_IDLE;
      ch_reg   <= '0;
      left_reg <= 5'h00;
      we_reg   <= 1'b0;
      sz_reg   <= 2'h0;
      bu_reg   <= BURST_SINGLE;
    end else begin
      st_reg   <= st_next;
      ch_reg   <= ch_next;
      left_reg <= left_next;
      we_reg   <= we_next;
      sz_reg   <= sz_next;
      bu_reg   <= bu_next;
    end
  end

  assign valid_o = (st_reg == DCDP_BUSY);
  assign beat_o  = valid_o & ready_i;
  assign we_o    = we_reg;
  assign size_o  = sz_reg;
  assign burst_o = bu_reg;
  assign addr_o  = addr_i[ch_reg];
  assign grant_o = valid_o ? ch_reg : pick;
endmodule
`default_nettype wire

// ==== sim/dcdp_chk.sv ====
// port checker for the dma channel data process core
`timescale 1ns/100ps
`default_nettype none
module dcdp_chk (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic [7:0]  periph_ack_o,
  input  wire logic        mem_valid_o,
  input  wire logic        mem_ready_i,
  input  wire logic [31:0] mem_addr_o,
  input  wire logic [1:0]  mem_size_o,
  input  wire logic [1:0]  mem_burst_o,
  input  wire logic        per_valid_o,
  input  wire logic        per_ready_i,
  input  wire logic [31:0] per_addr_o,
  input  wire logic [1:0]  per_burst_o
);
  // one clock domain for all checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held");
  ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  mem_hold_a: assert property (
    mem_valid_o && !mem_ready_i |=> mem_valid_o &&
    $stable({mem_burst_o, mem_addr_o}))
    else $error("memory beat dropped");
  per_hold_a: assert property (
    per_valid_o && !per_ready_i |=> per_valid_o && $stable(per_burst_o))
    else $error("peripheral beat dropped");
  mem_step_a: assert property (
    mem_valid_o && mem_ready_i |=> !mem_valid_o || mem_addr_o ==
    $past(mem_addr_o) + {29'h0, mem_size_o[1], mem_size_o == 2'h1,
    mem_size_o == 2'h0}) else $error("memory address step wrong");
  ack_start_a: assert property (|periph_ack_o |=> per_valid_o)
    else $error("ack without transfer");
  ack_one_a: assert property ($onehot0(periph_ack_o))
    else $error("two channels granted");
  rst_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !mem_valid_o && !per_valid_o)
    else $error("activity in reset");
  // main scenarios reached
  cover property (mem_valid_o && mem_ready_i && mem_size_o == 2'h2);
  cover property (|periph_ack_o);
  cover property (per_valid_o && per_burst_o != 2'h0);
endmodule
bind dcdp_core dcdp_chk i_chk (.*);
`default_nettype wire

// ==== sim/dcdp_slave.sv ====
// bus slave model with random stalls and a byte memory
`timescale 1ns/100ps
`default_nettype none
module dcdp_slave #(parameter logic [7:0] K = 8'h00) (
  input  wire logic        clk_i,
  input  wire logic        valid_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] wdata_i,
  output logic             ready_o,
  output logic      [31:0] rdata_o
);
  logic [7:0]  m [0:1023];
  logic [31:0] last;
  logic [9:0]  a;
  assign a = addr_i[9:0];
  // fill with a known pattern
  initial begin
    for (int i = 0; i < 1024; i++) m[i] = 8'(i) ^ K;
    ready_o = 1'b0;
    last = 32'h0;
  end
  // accept writes, stall at random
  always @(posedge clk_i) begin
    if (valid_i && ready_o && we_i)
      for (int i = 0; i < (1 << size_i) && i < 4; i++)
        m[a + 10'(i)] <= wdata_i[8*i +: 8];
    ready_o <= ($urandom % 3) != 0;
    if (ready_o) last <= rdata_o;
  end
  // data only in the beat cycle, scrambled otherwise
  always @* rdata_o = ready_o ? {m[a + 10'h3], m[a + 10'h2],
                                 m[a + 10'h1], m[a]} : ~last;
endmodule
`default_nettype wire

// ==== sim/dcdp_core_tb.sv ====
// bench: register access and transfers in every direction
`timescale 1ns/100ps
`default_nettype none
module dcdp_core_tb;
  import dcdp_pkg::*;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
  logic        wb_we_i = 0, wb_ack_o, mem_valid_o, mem_we_o;
  logic        mem_ready_i, per_valid_o, per_we_o, per_ready_i;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [1:0]  mem_size_o, mem_burst_o, per_size_o, per_burst_o;
  logic [7:0]  periph_req_i = 0, periph_ack_o, q[$];
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, mem_addr_o, r;
  logic [31:0] mem_wdata_o, mem_rdata_i, per_addr_o, per_wdata_o;
  logic [31:0] per_rdata_i;
  int          n_mismatch = 0, checks_done = 0;
  dcdp_core i_dut (.*);
  dcdp_slave #(.K(8'hA5)) i_mem (.clk_i, .valid_i(mem_valid_o),
    .we_i(mem_we_o), .addr_i(mem_addr_o), .size_i(mem_size_o),
    .wdata_i(mem_wdata_o), .ready_o(mem_ready_i), .rdata_o(mem_rdata_i));
  dcdp_slave #(.K(8'h3C)) i_per (.clk_i, .valid_i(per_valid_o),
    .we_i(per_we_o), .addr_i(per_addr_o), .size_i(per_size_o),
    .wdata_i(per_wdata_o), .ready_o(per_ready_i), .rdata_o(per_rdata_i));
  // clock
  initial forever #2.5 clk_i = ~clk_i;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // classic bus cycle, read data left in r
  task automatic wb(input logic w, input logic [31:0] a, d);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k == 50) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  // one channel transfer, destination checked byte by byte
  task automatic xf(input int c, input logic [1:0] d, pw, mw, pb, mb,
    input logic [2:0] f, input int n, input logic [31:0] pa, ma);
    int k;
    logic [31:0] b;
    b = c << 5;
    wb(1, b + 4, n);
    wb(1, b + 8, pa);
    wb(1, b + 12, ma);
    wb(1, b + 16, f);
    for (int i = 0; i < (n << pw); i++)
      q.push_back(d == DIR_M2P ? 8'(ma + i) ^ 8'hA5 : 8'(pa + i) ^ 8'h3C);
    periph_req_i[c] <= d != DIR_M2M;
    wb(1, b, ($urandom % 4) << 11 | mb << 9 | pb << 7 | mw << 5 | pw << 3
      | d << 1 | 1);
    k = 0;
    do begin
      wb(0, b, 0);
      k++;
    end while (r[0] !== 1'b0 && k < 3000);
    periph_req_i[c] <= 1'b0;
    if (k == 3000) begin
      n_mismatch++;
      end_sim;
    end
    wb(0, b + 4, 0);
    chk(r, 32'h0);
    for (int i = 0; q.size() > 0; i++)
      chk(d == DIR_M2P ? i_per.m[10'(pa + i)] : i_mem.m[10'(ma + i)],
        q.pop_front());
  endtask
  // main sequence
  initial begin
    r = $urandom(73);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 32'h40, 0);
    chk(r, 32'(CTRL_RST));
    wb(0, 32'h5C, 0);
    chk(r, 32'h0);
    wb(1, 32'h40, 32'h7);
    wb(0, 32'h40, 0);
    chk(r[0], 1'b0);
    wb(1, 32'h64, 32'h5);
    wb(1, 32'h60, 32'h2001);
    wb(0, 32'h64, 0);
    chk(r, 32'hFFFF);
    wb(1, 32'h60, 32'h2000);
    $display("test 1 done");
    for (int i = 0; i < 9; i++)
      xf($urandom % 8, DIR_M2M, i % 3, i / 3, 0, 0, 3'h4 | $urandom % 4,
        8, ($urandom % 256) << 2, 32'h100);
    $display("test 2 done");
    xf(1, DIR_M2M, 2, 2, 1, 1, 3'h7, 8, 32'h3F8, 32'h200);
    xf(2, DIR_P2M, 0, 2, 2, 1, 3'h0, 6, 32'h10, 32'h300);
    xf(5, DIR_P2M, 1, 2, 1, 0, 3'h5, 6, 32'h80, 32'h380);
    xf(6, DIR_M2P, 2, 0, 0, 0, 3'h7, 4, 32'h0, 32'h40);
    $display("test 3 done");
    end_sim;
  end
endmodule
`default_nettype wire
